// ---- rtl/fecmd_engine.sv ----
// Filter engine command handler: decodes host commands and loads coefficients and data
// Contract
// - Code 04 first transfer gives a11, b10
// - IIR holds three plus five coefficients
// - IIR bursts: (b11,a21),(a22,b20),(b21,b22)
// - Repeated same command during burst taken as burst word
// - Data write raises accept pending until consumed
// - Host waits for accept pending low
// - Code 05 selects built-in coefficient sets
// - Code 06 first transfer gives value count
// - Bitstream values follow as paced bursts
// - Code 07 selects built-in bitstream data
// - Code 08 initialises and starts filters
// - Start applies filter setup at 0x20
// - Code 09 halts sinc stages, stops chain
// - Host may lower engine clock after stop
// - Code 01 writes addressed engine register
// - Code 02 reads register into data one
// - FIR counts up to 255 each, bursts
// - Accept pending is control bit 8
`timescale 1ns/10ps
module fecmd_engine
  import fecmd_pkg::*;
(
  // Link to the host controller
  fecmd_link_if.engine                   link,
  // Filter chain control
  output logic                           filt_run,
  output logic                           sinc_halt,
  output logic [DATA_W-1:0]              active_setup,
  output logic [DATA_W-1:0]              engine_configuration,
  // Coefficient source and contents
  output logic                           coef_builtin,
  output logic [IIR_N-1:0][DATA_W-1:0]   iir_coef,
  output logic [7:0]                     fir1_num,
  output logic [7:0]                     fir2_num,
  input  logic [FIR_AW-1:0]              fir_rd_addr,
  output logic [DATA_W-1:0]              fir_rd_data,
  // Test bitstream source and contents
  output logic                           tbit_builtin,
  output logic [TBIT_AW:0]               tbit_num,
  input  logic [TBIT_AW-1:0]             tbit_rd_addr,
  output logic [DATA_W-1:0]              tbit_rd_data
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_IIR  = 2'b01,
    ST_FIR  = 2'b11,
    ST_TBIT = 2'b10
  } fecmd_state_t;

  typedef struct packed {
    fecmd_state_t                          state;
    logic [CMD_W-1:0]                      run_cmd;
    logic                                  pend;
    logic                                  cmd_wr;
    logic [CMD_W-1:0]                      cmd;
    logic [DATA_W-1:0]                     dat1;
    logic [DATA_W-1:0]                     dat2;
    logic [10:0]                           cnt;      // Wide enough for a full 1024 value upload
    logic [9:0]                            idx;
    logic                                  run;
    logic                                  coef_rom;
    logic                                  tbit_rom;
    logic [DATA_W-1:0]                     setup;
    logic [DATA_W-1:0]                     rd_data;
    logic [7:0]                            fir1;
    logic [7:0]                            fir2;
    logic [TBIT_AW:0]                      tbit_n;
    logic [IIR_N-1:0][DATA_W-1:0]          iir;
    logic [(1<<ENG_AW)-1:0][DATA_W-1:0]    regs;
    logic [DATA_W-1:0]                     fir_rd;
    logic [DATA_W-1:0]                     tbit_rd;
  } fecmd_eng_t;

  fecmd_eng_t        q;
  fecmd_eng_t        d;
  logic [DATA_W-1:0] fir_mem  [FIR_DEPTH];
  logic [DATA_W-1:0] tbit_mem [1<<TBIT_AW];
  logic              mem_we1;
  logic              mem_we2;
  logic              mem_fir;
  logic [9:0]        mem_a1;
  logic [9:0]        mem_a2;
  logic              new_cmd;
  logic [2:0]        iir_ia;
  logic [10:0]       tbit_cnt;

  // Decode, burst sequencing and register file
  always_comb begin
    d         = q;
    mem_we1   = 1'b0;
    mem_we2   = 1'b0;
    mem_fir   = 1'b0;
    mem_a1    = q.idx;
    mem_a2    = 10'(q.idx + 10'h001);
    iir_ia    = 3'({q.idx[1:0], 1'b0} + IIR_BURST_OFS);
    tbit_cnt  = (q.dat1 > 24'(TBIT_DEPTH)) ? TBIT_DEPTH : q.dat1[10:0];
    new_cmd   = q.cmd_wr && ((q.state == ST_IDLE) || (q.cmd != q.run_cmd));
    d.fir_rd  = fir_mem[fir_rd_addr];
    d.tbit_rd = tbit_mem[tbit_rd_addr];
    // Consume the latched transfer one cycle after it arrives
    if (q.pend) begin
      d.pend = 1'b0;
      if (new_cmd) begin
        d.state   = ST_IDLE;
        d.run_cmd = q.cmd;
        d.idx     = 10'h000;
        case (q.cmd)
          CMD_REG_WR: begin
            if (q.dat1[DATA_W-1:ENG_AW] == '0) begin
              d.regs[q.dat1[ENG_AW-1:0]] = q.dat2;
            end
          end
          CMD_REG_RD: begin
            d.rd_data = (q.dat1[DATA_W-1:ENG_AW] == '0) ? q.regs[q.dat1[ENG_AW-1:0]] : '0;
          end
          CMD_FIR_WR: begin
            d.fir1     = q.dat1[7:0];
            d.fir2     = q.dat2[7:0];
            d.cnt      = 11'(q.dat1[7:0]) + 11'(q.dat2[7:0]);
            d.coef_rom = 1'b0;
            if ((q.dat1[7:0] != 8'h00) || (q.dat2[7:0] != 8'h00)) begin
              d.state = ST_FIR;
            end
          end
          CMD_IIR_WR: begin
            d.iir[IIR_IDX_A11] = q.dat1;
            d.iir[IIR_IDX_B10] = q.dat2;
            d.cnt              = 11'(IIR_BURSTS);
            d.coef_rom         = 1'b0;
            d.state            = ST_IIR;
          end
          CMD_ROM_COEF: begin
            d.coef_rom = 1'b1;
          end
          CMD_TBIT_WR: begin
            d.tbit_n   = tbit_cnt;
            d.cnt      = tbit_cnt;
            d.tbit_rom = 1'b0;
            if (tbit_cnt != 11'h000) begin
              d.state = ST_TBIT;
            end
          end
          CMD_TBIT_ROM: begin
            d.tbit_rom = 1'b1;
          end
          CMD_FILT_START: begin
            d.run   = 1'b1;
            d.setup = q.regs[ADDR_FILTER_SETUP];
          end
          CMD_FILT_STOP: begin
            d.run = 1'b0;
          end
          default: begin
            d.state   = q.state;
            d.run_cmd = q.run_cmd;
            d.idx     = q.idx;
          end
        endcase
      end else begin
        // Burst word: a repeated command code takes this path unchanged
        case (q.state)
          ST_IIR: begin
            d.iir[iir_ia]                 = q.dat1;
            d.iir[3'(iir_ia + 3'h1)]      = q.dat2;
            d.idx                         = 10'(q.idx + 10'h001);
            d.cnt                         = 11'(q.cnt - 11'h001);
            if (q.cnt == 11'h001) begin
              d.state = ST_IDLE;
            end
          end
          ST_FIR, ST_TBIT: begin
            mem_fir = (q.state == ST_FIR);
            mem_we1 = 1'b1;
            mem_we2 = (q.cnt >= 11'h002);
            d.idx   = 10'(q.idx + 10'h002);
            d.cnt   = (q.cnt >= 11'h002) ? 11'(q.cnt - 11'h002) : 11'h000;
            if (q.cnt <= 11'h002) begin
              d.state = ST_IDLE;
            end
          end
          default: begin
            d.state = ST_IDLE;
          end
        endcase
      end
    end
    // New transfer is latched; a set in the consuming cycle wins
    if (link.xfer) begin
      d.pend   = 1'b1;
      d.cmd_wr = link.cmd_wr;
      d.cmd    = link.cmd;
      d.dat1   = link.dat1;
      d.dat2   = link.dat2;
    end
  end

  // State register
  always_ff @(posedge link.clk or negedge link.resetn) begin
    if (!link.resetn) begin
      q          <= '0;
      q.state    <= ST_IDLE;
      q.coef_rom <= 1'b1;
      q.tbit_rom <= 1'b1;
      q.regs     <= {(1<<ENG_AW){ENG_REG_RST}};
    end else begin
      q <= d;
    end
  end

  // Coefficient and bitstream stores, two words per burst, one word on an odd last burst
  always_ff @(posedge link.clk) begin
    if (mem_we1 && mem_fir && (mem_a1 < 10'(FIR_DEPTH))) begin
      fir_mem[mem_a1[FIR_AW-1:0]] <= q.dat1;
    end
    if (mem_we2 && mem_fir && (mem_a2 < 10'(FIR_DEPTH))) begin
      fir_mem[mem_a2[FIR_AW-1:0]] <= q.dat2;
    end
    if (mem_we1 && !mem_fir) begin
      tbit_mem[mem_a1] <= q.dat1;
    end
    if (mem_we2 && !mem_fir) begin
      tbit_mem[mem_a2] <= q.dat2;
    end
  end

  // Outputs
  assign link.port_ctrl       = DATA_W'(q.pend) << CTRL_ACC_PEND_BIT;
  assign link.rd_data         = q.rd_data;
  assign filt_run             = q.run;
  assign sinc_halt            = ~q.run;
  assign active_setup         = q.setup;
  assign engine_configuration = q.regs[ADDR_ENGINE_CONFIGURATION];
  assign coef_builtin         = q.coef_rom;
  assign iir_coef             = q.iir;
  assign fir1_num             = q.fir1;
  assign fir2_num             = q.fir2;
  assign fir_rd_data          = q.fir_rd;
  assign tbit_builtin         = q.tbit_rom;
  assign tbit_num             = q.tbit_n;
  assign tbit_rd_data         = q.tbit_rd;

endmodule // fecmd_engine

// ---- rtl/fecmd_pkg.sv ----
// Shared constants for the filter engine command handler and its host controller
package fecmd_pkg;

  // Link widths
  localparam int unsigned CMD_W  = 8;
  localparam int unsigned DATA_W = 24;

  // Command codes carried in the command register
  localparam logic [7:0] CMD_REG_WR     = 8'h01;
  localparam logic [7:0] CMD_REG_RD     = 8'h02;
  localparam logic [7:0] CMD_FIR_WR     = 8'h03;
  localparam logic [7:0] CMD_IIR_WR     = 8'h04;
  localparam logic [7:0] CMD_ROM_COEF   = 8'h05;
  localparam logic [7:0] CMD_TBIT_WR    = 8'h06;
  localparam logic [7:0] CMD_TBIT_ROM   = 8'h07;
  localparam logic [7:0] CMD_FILT_START = 8'h08;
  localparam logic [7:0] CMD_FILT_STOP  = 8'h09;

  // Engine register file
  localparam int unsigned ENG_AW                    = 6;
  localparam logic [5:0]  ADDR_ENGINE_CONFIGURATION = 6'h00;
  localparam logic [5:0]  ADDR_FILTER_SETUP         = 6'h20;
  localparam logic [23:0] ENG_REG_RST               = 24'h00_0000;

  // Coefficient and test bitstream stores
  localparam int unsigned IIR_N         = 8;
  localparam logic [9:0]  IIR_BURSTS    = 10'h003;
  localparam int unsigned IIR_IDX_A11   = 0;
  localparam int unsigned IIR_IDX_B10   = 1;
  localparam logic [2:0]  IIR_BURST_OFS = 3'h2;
  localparam int unsigned FIR_AW        = 9;
  localparam int unsigned FIR_DEPTH     = 510;
  localparam int unsigned TBIT_AW       = 10;
  localparam logic [10:0] TBIT_DEPTH    = 11'h400;

  // Host port control layout
  localparam int unsigned CTRL_ACC_PEND_BIT = 8;

  // Host controller registers on the AHB-Lite side (byte offsets)
  localparam logic [7:0] HOST_OFS_CMD    = 8'h00;
  localparam logic [7:0] HOST_OFS_DAT1   = 8'h04;
  localparam logic [7:0] HOST_OFS_DAT2   = 8'h08;
  localparam logic [7:0] HOST_OFS_GO     = 8'h0C;
  localparam logic [7:0] HOST_OFS_STATUS = 8'h10;
  localparam logic [7:0] HOST_OFS_RDBACK = 8'h14;
  localparam int unsigned HOST_CMD_WITH_BIT = 8;
  localparam int unsigned HOST_GO_BIT       = 0;
  localparam int unsigned HOST_STAT_WAIT_BIT = 0;

endpackage

// ---- rtl/fecmd_link_if.sv ----
// Link between the host controller and the filter engine command handler
`timescale 1ns/10ps
interface fecmd_link_if
  import fecmd_pkg::*;
(
  input logic clk,
  input logic resetn
);
  logic              xfer;       // One-cycle write of command and data registers
  logic              cmd_wr;     // Command register is written in this transfer
  logic [CMD_W-1:0]  cmd;        // Command code
  logic [DATA_W-1:0] dat1;       // First data register
  logic [DATA_W-1:0] dat2;       // Second data register
  logic [DATA_W-1:0] port_ctrl;  // Host port control, accept pending at bit 8
  logic [DATA_W-1:0] rd_data;    // First data register as read back

  modport engine (input clk, resetn, xfer, cmd_wr, cmd, dat1, dat2, output port_ctrl, rd_data);
  modport host   (input clk, resetn, port_ctrl, rd_data, output xfer, cmd_wr, cmd, dat1, dat2);
endinterface

// ---- rtl/fecmd_host.sv ----
// Host controller: AHB-Lite registers that issue paced transfers to the engine
`timescale 1ns/10ps
module fecmd_host
  import fecmd_pkg::*;
(
  // Link to the engine
  fecmd_link_if.host        link,
  // AHB-Lite slave
  input  logic              hsel,
  input  logic [31:0]       haddr,
  input  logic [1:0]        htrans,
  input  logic              hwrite,
  input  logic [2:0]        hsize,
  input  logic [31:0]       hwdata,
  input  logic              hready,
  output logic              hreadyout,
  output logic              hresp,
  output logic [31:0]       hrdata
);

  typedef struct packed {
    logic              wr_pend;
    logic [7:0]        waddr;
    logic [31:0]       rdata;
    logic [CMD_W-1:0]  cmd;
    logic              with_cmd;
    logic [DATA_W-1:0] dat1;
    logic [DATA_W-1:0] dat2;
    logic              waiting;
    logic              xfer;
  } fecmd_host_t;

  fecmd_host_t q;
  fecmd_host_t d;
  logic        acc_pend;

  assign acc_pend = link.port_ctrl[CTRL_ACC_PEND_BIT];

  // Bus decode and transfer pacing
  always_comb begin
    d      = q;
    d.xfer = 1'b0;
    // Send only after the engine has accepted the previous word
    if (q.waiting && !acc_pend && !q.xfer) begin
      d.xfer    = 1'b1;
      d.waiting = 1'b0;
    end
    // Write data phase
    if (q.wr_pend) begin
      d.wr_pend = 1'b0;
      case (q.waddr)
        HOST_OFS_CMD: begin
          d.cmd      = hwdata[CMD_W-1:0];
          d.with_cmd = hwdata[HOST_CMD_WITH_BIT];
        end
        HOST_OFS_DAT1: d.dat1 = hwdata[DATA_W-1:0];
        HOST_OFS_DAT2: d.dat2 = hwdata[DATA_W-1:0];
        HOST_OFS_GO: begin
          if (hwdata[HOST_GO_BIT]) begin
            d.waiting = 1'b1;
          end
        end
        default: d.wr_pend = 1'b0;
      endcase
    end
    // Address phase
    if (hsel && htrans[1] && hready) begin
      d.wr_pend = hwrite;
      d.waddr   = haddr[7:0];
      d.rdata   = 32'h0000_0000;
      if (!hwrite) begin
        case (haddr[7:0])
          HOST_OFS_CMD:    d.rdata = 32'({q.with_cmd, q.cmd});
          HOST_OFS_DAT1:   d.rdata = 32'(q.dat1);
          HOST_OFS_DAT2:   d.rdata = 32'(q.dat2);
          HOST_OFS_STATUS: d.rdata = 32'(link.port_ctrl) | 32'(q.waiting | q.xfer);
          HOST_OFS_RDBACK: d.rdata = 32'(link.rd_data);
          default:         d.rdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge link.clk or negedge link.resetn) begin
    if (!link.resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs
  assign link.xfer   = q.xfer;
  assign link.cmd_wr = q.with_cmd;
  assign link.cmd    = q.cmd;
  assign link.dat1   = q.dat1;
  assign link.dat2   = q.dat2;
  assign hreadyout   = 1'b1;
  assign hresp       = 1'b0;
  assign hrdata      = q.rdata;

endmodule // fecmd_host

// ---- testbench/fecmd_link_props.sv ----
// Assertions on the link between host controller and engine
`timescale 1ns/10ps
module fecmd_link_props
  import fecmd_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  // Host to engine
  input wire logic              xfer,
  input wire logic              cmd_wr,
  input wire logic [CMD_W-1:0]  cmd,
  input wire logic [DATA_W-1:0] dat1,
  input wire logic [DATA_W-1:0] dat2,
  // Engine to host
  input wire logic [DATA_W-1:0] port_ctrl,
  input wire logic [DATA_W-1:0] rd_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Accept pending flag taken from the control word
  logic pend;
  assign pend = port_ctrl[CTRL_ACC_PEND_BIT];

  chk_pend_pulse: assert property (xfer |=> pend ##1 !pend)
    else $error("pending flag not a one cycle pulse after a transfer");
  chk_pend_cause: assert property (pend |-> $past(xfer))
    else $error("pending flag raised without a transfer");
  chk_host_waits: assert property (xfer |-> !pend)
    else $error("transfer sent while pending");
  chk_xfer_gap: assert property (xfer |=> !xfer)
    else $error("transfers closer than two cycles");
  chk_ctrl_bits: assert property ({port_ctrl[23:9], port_ctrl[7:0]} == '0)
    else $error("control bits other than pending are set");
  chk_rd_cause: assert property ($changed(rd_data) |-> $past(xfer, 2) && $past(cmd, 2) == CMD_REG_RD)
    else $error("read back changed without a read command");
  chk_rd_far: assert property (xfer && cmd_wr && cmd == CMD_REG_RD && dat1 >= 64 |-> ##2 rd_data == '0)
    else $error("read of missing register not zero");
  chk_rd_keep: assert property (xfer && cmd_wr && cmd != CMD_REG_RD |-> ##2 rd_data == $past(rd_data, 2))
    else $error("read back changed by another command");

  // Main traffic kinds
  cov_iir_burst: cover property (xfer && !cmd_wr && cmd == CMD_IIR_WR);
  cov_tbit_burst: cover property (xfer && !cmd_wr && cmd == CMD_TBIT_WR);
  cov_stop: cover property (xfer && cmd_wr && cmd == CMD_FILT_STOP);
endmodule // fecmd_link_props

// ---- testbench/filter_engine_command_handler_bench.sv ----
// Testbench joining host controller and engine, driven over AHB-Lite
`timescale 1ns/10ps
module filter_engine_command_handler_bench;
  import fecmd_pkg::*;
  typedef struct {logic [3:0] st; int sel; logic [47:0] v;} fecmd_note_t;
  logic                       clk;
  logic                       resetn;
  logic                       hsel;
  logic                       hwrite;
  logic                       hreadyout;
  logic                       hresp;
  logic [1:0]                 htrans;
  logic [2:0]                 hsize;
  logic [31:0]                haddr;
  logic [31:0]                hwdata;
  logic [31:0]                hrdata;
  logic [31:0]                r;
  logic                       filt_run;
  logic                       sinc_halt;
  logic                       coef_builtin;
  logic                       tbit_builtin;
  logic [DATA_W-1:0]          active_setup;
  logic [DATA_W-1:0]          engine_configuration;
  logic [DATA_W-1:0]          fir_rd_data;
  logic [DATA_W-1:0]          tbit_rd_data;
  logic [IIR_N-1:0][DATA_W-1:0] iir_coef;
  logic [7:0]                 fir1_num;
  logic [7:0]                 fir2_num;
  logic [FIR_AW-1:0]          fir_rd_addr;
  logic [TBIT_AW:0]           tbit_num;
  logic [TBIT_AW-1:0]         tbit_rd_addr;
  logic [3:0]                 st;
  logic [23:0]                d [6];
  fecmd_note_t                notes [$];
  int                         n_fail;
  int                         tests_run;
  int                         seed;

  fecmd_link_if lk (.clk(clk), .resetn(resetn));
  fecmd_host fecmd_host_i (.link(lk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  fecmd_engine fecmd_engine_i (.link(lk), .filt_run(filt_run), .sinc_halt(sinc_halt),
    .active_setup(active_setup), .engine_configuration(engine_configuration), .coef_builtin(coef_builtin),
    .iir_coef(iir_coef), .fir1_num(fir1_num), .fir2_num(fir2_num), .fir_rd_addr(fir_rd_addr),
    .fir_rd_data(fir_rd_data), .tbit_builtin(tbit_builtin), .tbit_num(tbit_num),
    .tbit_rd_addr(tbit_rd_addr), .tbit_rd_data(tbit_rd_data));
  fecmd_link_props fecmd_link_props_i (.clk(clk), .resetn(resetn), .xfer(lk.xfer), .cmd_wr(lk.cmd_wr),
    .cmd(lk.cmd), .dat1(lk.dat1), .dat2(lk.dat2), .port_ctrl(lk.port_ctrl), .rd_data(lk.rd_data));

  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Comparison, verdict and bounded handshake wait
  task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (k >= 64) begin
      n_fail++;
      give_verdict;
    end
  endtask

  // One single-word AHB-Lite transfer; read data lands in r
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] dv);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= 3'b010;
    rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= dv;
    rdy;
    r = hrdata;
    chk("response", 48'(hresp), 48'h0000_0000_0000);
  endtask

  // Note the expectation, load the host registers, queue one transfer, poll until it is done
  task send(input logic [7:0] c, input logic w, input logic [23:0] d1, input logic [23:0] d2,
            input int sel, input logic [47:0] v);
    int k;
    notes.push_back('{st, sel, v});
    ahb(1'b1, HOST_OFS_CMD, {23'h00_0000, w, c});
    ahb(1'b1, HOST_OFS_DAT1, {8'h00, d1});
    ahb(1'b1, HOST_OFS_DAT2, {8'h00, d2});
    ahb(1'b1, HOST_OFS_GO, 32'h0000_0001);
    k = 0;
    do begin
      ahb(1'b0, HOST_OFS_STATUS, 32'h0000_0000);
      k++;
    end while ((r[0] | r[8]) !== 1'b0 && k < 64);
    if (k >= 64) begin
      n_fail++;
      give_verdict;
    end
  endtask

  // Engine output chosen by a note
  function automatic logic [47:0] obs(int s);
    case (s)
      1: obs = 48'(lk.rd_data);
      2: obs = 48'(engine_configuration);
      3: obs = 48'(active_setup);
      4, 5, 6, 7: obs = {iir_coef[2*(s-4)], iir_coef[2*(s-4)+1]};
      8: obs = 48'(tbit_num);
      9: obs = 48'({fir1_num, fir2_num});
      default: obs = 48'h0000_0000_0000;
    endcase
  endfunction

  // Watcher: two edges after each transfer, compare against the oldest note
  initial begin
    fecmd_note_t n;
    forever begin
      @(posedge clk);
      #1;
      if (lk.xfer === 1'b1) begin
        repeat (2) @(posedge clk);
        #1;
        if (notes.size() == 0) chk("note queue", 48'h0000_0000_0000, 48'h0000_0000_0001);
        else begin
          n = notes.pop_front();
          chk("status", 48'({filt_run, sinc_halt, coef_builtin, tbit_builtin}), 48'(n.st));
          chk("value", obs(n.sel), n.v);
        end
      end
    end
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    give_verdict;
  end

  // Main sequence
  initial begin
    seed = 83;
    n_fail = 0;
    tests_run = 0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    fir_rd_addr = '0;
    tbit_rd_addr = '0;
    resetn = 1'b0;
    st = 4'b0111;
    for (int i = 0; i < 6; i++) d[i] = 24'($random(seed));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("reset status", 48'({filt_run, sinc_halt, coef_builtin, tbit_builtin}), 48'h0000_0000_0007);
    ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
    ahb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped", 48'(r), 48'h0000_0000_0000);
    send(CMD_REG_WR, 1'b1, 24'(ADDR_ENGINE_CONFIGURATION), d[0], 2, 48'(d[0]));
    send(CMD_REG_WR, 1'b1, 24'h00_0040, d[1], 2, 48'(d[0]));
    send(CMD_REG_WR, 1'b1, 24'(ADDR_FILTER_SETUP), d[1], 3, 48'h0000_0000_0000);
    send(CMD_REG_RD, 1'b1, 24'(ADDR_FILTER_SETUP), 24'h00_0000, 1, 48'(d[1]));
    ahb(1'b0, HOST_OFS_RDBACK, 32'h0000_0000);
    chk("readback", 48'(r), 48'(d[1]));
    send(CMD_REG_RD, 1'b1, 24'h00_0046, 24'h00_0000, 1, 48'h0000_0000_0000);
    st[1] = 1'b0;
    send(CMD_IIR_WR, 1'b1, d[0], d[1], 4, {d[0], d[1]});
    for (int i = 0; i < 3; i++) send(CMD_IIR_WR, i[0], d[(2*i+2)%6], d[(2*i+3)%6], 5+i, {d[(2*i+2)%6], d[(2*i+3)%6]});
    send(8'h0A, 1'b1, d[4], d[5], 5, {d[2], d[3]});
    st[1] = 1'b1;
    send(CMD_ROM_COEF, 1'b1, 24'h00_0000, 24'h00_0000, 0, 48'h0000_0000_0000);
    st[1] = 1'b0;
    send(CMD_FIR_WR, 1'b1, 24'h00_0002, 24'h00_0001, 9, 48'h0000_0000_0201);
    send(CMD_FIR_WR, 1'b0, d[2], d[3], 9, 48'h0000_0000_0201);
    send(CMD_FIR_WR, 1'b0, d[4], d[5], 9, 48'h0000_0000_0201);
    st[0] = 1'b0;
    send(CMD_TBIT_WR, 1'b1, 24'h00_0003, 24'h00_0000, 8, 48'h0000_0000_0003);
    send(CMD_TBIT_WR, 1'b0, d[0], d[1], 8, 48'h0000_0000_0003);
    send(CMD_TBIT_WR, 1'b1, d[2], d[3], 8, 48'h0000_0000_0003);
    for (int i = 0; i < 3; i++) begin
      fir_rd_addr <= FIR_AW'(i);
      tbit_rd_addr <= TBIT_AW'(i);
      repeat (2) @(posedge clk);
      chk("fir word", 48'(fir_rd_data), 48'(d[2+i]));
      chk("bitstream word", 48'(tbit_rd_data), 48'(d[i]));
    end
    st[0] = 1'b1;
    send(CMD_TBIT_ROM, 1'b1, 24'h00_0000, 24'h00_0000, 0, 48'h0000_0000_0000);
    st[3:2] = 2'b10;
    send(CMD_FILT_START, 1'b1, 24'h00_0000, 24'h00_0000, 3, 48'(d[1]));
    st[3:2] = 2'b01;
    send(CMD_FILT_STOP, 1'b1, 24'h00_0000, 24'h00_0000, 3, 48'(d[1]));
    send(CMD_REG_WR, 1'b1, 24'(ADDR_ENGINE_CONFIGURATION), d[5], 2, 48'(d[5]));
    repeat (4) @(posedge clk);
    chk("open notes", 48'(notes.size()), 48'h0000_0000_0000);
    give_verdict;
  end
endmodule // filter_engine_command_handler_bench
